// >>> hdl/gcr_regs.svh
/*
  Register offsets, field positions, reset values and timing figures of
  the gain and clock configuration bank. Definitions only.
  Assumes a 125 MHz system clock and a 1 MHz master clock.
*/
`ifndef GCR_REGS_SVH
`define GCR_REGS_SVH

`define GCR_ADDR_GAIN        7'h00
`define GCR_ADDR_SRST        7'h01
`define GCR_ADDR_SYNC        7'h02
`define GCR_ADDR_DERR        7'h03

`define GCR_GAIN_SCALE_BIT   7
`define GCR_GAIN_CODE_MSB    6
`define GCR_GAIN_CODE_LSB    3
`define GCR_GAIN_EXT_MSB     1
`define GCR_GAIN_EXT_LSB     0
`define GCR_GAIN_CODE_MAX    4'hb
`define GCR_SRST_BIT         0
`define GCR_SYNC_PUMP_BIT    7
`define GCR_SYNC_CLKOUT_BIT  6
`define GCR_SYNC_EDGE_POLARITY_BIT     4
`define GCR_SYNC_DIV_MSB     2
`define GCR_SYNC_DIV_LSB     0
`define GCR_SYNC_DIV_MAX     3'h5
`define GCR_DERR_CAL_BIT     6
`define GCR_DERR_FLAG_MASK   8'h3b
`define GCR_DERR_SPI_CRC     5
`define GCR_DERR_SPI_RW      4
`define GCR_DERR_SCLK_CNT    3
`define GCR_DERR_MAP_CHK     1
`define GCR_DERR_ROM_CRC     0

`define GCR_RST_GAIN_CODE    4'h0
`define GCR_RST_EXT_CODE     2'h0
`define GCR_RST_SYNC_DIV     3'h4
`define GCR_RST_FLAGS        8'h00

`define GCR_SYS_KHZ          125000
`define GCR_MCLK_KHZ         1000
`define GCR_CHOP_KHZ         125
`define GCR_PUMP_FAST_KHZ    16000
`define GCR_PUMP_SLOW_KHZ    8000
`define GCR_MCLK_CYCLES      (`GCR_SYS_KHZ / `GCR_MCLK_KHZ)
`define GCR_CHOP_TICKS       (`GCR_MCLK_KHZ / `GCR_CHOP_KHZ)
`define GCR_CAL_CYCLES       1000

`define GCR_FRAME_BITS       16
`define GCR_CMD_BITS         8

`endif

// >>> hdl/gcr_pkg.sv
/*
  Types shared by the gain and clock configuration bank.
  Assumes nothing of its surroundings.
*/
package gcr_pkg;
  typedef enum logic [1:0] {
    GCR_SCALE_1    = 2'b00,
    GCR_SCALE_1P25 = 2'b01,
    GCR_SCALE_1P375 = 2'b10
  } gcr_scale_t;

  typedef enum logic [1:0] {
    GCR_SPI_IDLE = 2'b00,
    GCR_SPI_CMD  = 2'b01,
    GCR_SPI_DATA = 2'b10
  } gcr_spi_state_t;

  typedef enum logic [0:0] {
    GCR_CAL_IDLE = 1'b0,
    GCR_CAL_RUN  = 1'b1
  } gcr_cal_state_t;
endpackage : gcr_pkg

// >>> hdl/gcr_spi.sv
/*
  Serial port frame engine: 16-bit frames, read flag, 7-bit address,
  8 data bits, mode 0. Pins are sampled on clk and must be slow
  against it (at least four clk cycles per serial half period).
*/
`timescale 1ns/10ps
`include "gcr_regs.svh"
module gcr_spi (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic [7:0] rdata,
  output logic            miso,
  output logic            miso_oe,
  output logic            addr_strobe,
  output logic            rd_frame,
  output logic [6:0]      addr,
  output logic            wr_strobe,
  output logic [7:0]      wdata,
  output logic            count_error
);
  gcr_pkg::gcr_spi_state_t state;
  logic       sclk_q;
  logic       cs_q;
  logic [4:0] bits;
  logic [15:0] shift_in;
  logic [7:0] shift_out;
  logic       rise;
  logic       fall;
  logic       frame_end;

  assign rise      = sclk & ~sclk_q & ~cs_n;
  assign fall      = ~sclk & sclk_q & ~cs_n;
  assign frame_end = cs_n & ~cs_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
    end else begin
      sclk_q <= sclk;
      cs_q   <= cs_n;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= gcr_pkg::GCR_SPI_IDLE;
      bits     <= 5'h00;
      shift_in <= 16'h0000;
    end else begin
      case (state)
        gcr_pkg::GCR_SPI_IDLE: begin
          bits <= 5'h00;
          if (!cs_n) begin
            state <= gcr_pkg::GCR_SPI_CMD;
          end
        end
        gcr_pkg::GCR_SPI_CMD, gcr_pkg::GCR_SPI_DATA: begin
          if (rise) begin
            shift_in <= {shift_in[14:0], mosi};
            if (bits != 5'h1f) begin
              bits <= bits + 5'h01;
            end
            if (bits == 5'(`GCR_CMD_BITS - 1)) begin
              state <= gcr_pkg::GCR_SPI_DATA;
            end
          end
          if (frame_end) begin
            state <= gcr_pkg::GCR_SPI_IDLE;
          end
        end
        default: begin
          state <= gcr_pkg::GCR_SPI_IDLE;
        end
      endcase
    end
  end

  // Strobes and decoded frame fields
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_strobe <= 1'b0;
      wr_strobe   <= 1'b0;
      count_error <= 1'b0;
      rd_frame    <= 1'b0;
      addr        <= 7'h00;
      wdata       <= 8'h00;
    end else begin
      addr_strobe <= 1'b0;
      wr_strobe   <= 1'b0;
      count_error <= 1'b0;
      if (rise && state == gcr_pkg::GCR_SPI_CMD &&
          bits == 5'(`GCR_CMD_BITS - 1)) begin
        rd_frame    <= shift_in[6];
        addr        <= {shift_in[5:0], mosi};
        addr_strobe <= 1'b1;
      end
      if (frame_end && state != gcr_pkg::GCR_SPI_IDLE) begin
        if (bits != 5'(`GCR_FRAME_BITS)) begin
          count_error <= 1'b1;
        end else if (!rd_frame) begin
          wdata     <= shift_in[7:0];
          wr_strobe <= 1'b1;
        end
      end
    end
  end

  // Read data loads one cycle after the address and shifts on falls
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_out <= 8'h00;
      miso      <= 1'b0;
      miso_oe   <= 1'b0;
    end else begin
      miso_oe <= ~cs_n;
      // MSB leaves on the fall after the address, ready for data rise one
      if (addr_strobe) begin
        shift_out <= rdata;
      end else if (fall && state == gcr_pkg::GCR_SPI_DATA) begin
        miso      <= shift_out[7];
        shift_out <= {shift_out[6:0], 1'b0};
      end
    end
  end
endmodule : gcr_spi

// >>> hdl/gcr_clkgen.sv
/*
  Clock generation: 1 MHz master tick (internal or from an external
  clock), 125 kHz chop clock and the charge pump clock. All outputs
  are levels or one-cycle enables in the clk domain.
*/
`timescale 1ns/10ps
`include "gcr_regs.svh"
module gcr_clkgen (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       pump_slow,
  input  wire logic       ext_mode,
  input  wire logic       ext_clk,
  input  wire logic       ext_rising,
  input  wire logic [2:0] ext_div,
  output logic            mclk_level,
  output logic            chop_level,
  output logic            chop_tick,
  output logic            pump_level
);
  logic [6:0]  mcnt;
  logic        int_tick;
  logic        ext_q;
  logic        ext_edge;
  logic [4:0]  ecnt;
  logic        ext_tick;
  logic        ext_level;
  logic        mtick;
  logic [2:0]  ccnt;
  logic [17:0] acc;
  logic [17:0] acc_sum;

  assign int_tick = (mcnt == 7'(`GCR_MCLK_CYCLES - 1));
  assign ext_edge = ext_rising ? (ext_clk & ~ext_q) : (~ext_clk & ext_q);
  assign ext_tick = ext_edge && ecnt == 5'((6'h01 << ext_div) - 6'h01);
  assign mtick    = ext_mode ? ext_tick : int_tick;
  assign acc_sum  = acc + (pump_slow ? 18'(2 * `GCR_PUMP_SLOW_KHZ)
                                     : 18'(2 * `GCR_PUMP_FAST_KHZ));

  always_ff @(posedge clk) begin
    if (rst) begin
      mcnt <= 7'h00;
    end else if (int_tick) begin
      mcnt <= 7'h00;
    end else begin
      mcnt <= mcnt + 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ext_q     <= 1'b0;
      ecnt      <= 5'h00;
      ext_level <= 1'b0;
    end else begin
      ext_q <= ext_clk;
      if (ext_tick) begin
        ecnt      <= 5'h00;
        ext_level <= ~ext_level;
      end else if (ext_edge) begin
        ecnt <= ecnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mclk_level <= 1'b0;
    end else if (ext_mode) begin
      mclk_level <= ext_level;
    end else begin
      mclk_level <= (mcnt < 7'(`GCR_MCLK_CYCLES / 2));
    end
  end

  // Chop clock: one full period per eight master ticks
  always_ff @(posedge clk) begin
    if (rst) begin
      ccnt       <= 3'h0;
      chop_level <= 1'b0;
      chop_tick  <= 1'b0;
    end else begin
      chop_tick <= 1'b0;
      if (mtick) begin
        ccnt <= ccnt + 3'h1;
        if (ccnt == 3'(`GCR_CHOP_TICKS / 2 - 1) ||
            ccnt == 3'(`GCR_CHOP_TICKS - 1)) begin
          chop_level <= ~chop_level;
          chop_tick  <= ~chop_level;
        end
      end
    end
  end

  // Fractional accumulator: 16 and 8 MHz do not divide 125 MHz evenly
  always_ff @(posedge clk) begin
    if (rst) begin
      acc        <= 18'h00000;
      pump_level <= 1'b0;
    end else if (acc_sum >= 18'(`GCR_SYS_KHZ)) begin
      acc        <= acc_sum - 18'(`GCR_SYS_KHZ);
      pump_level <= ~pump_level;
    end else begin
      acc <= acc_sum;
    end
  end
endmodule : gcr_clkgen

// >>> hdl/gcr_bank.sv
/*
  Configuration register bank of the amplifier front end: gain and
  selector register, soft reset, clock synchronisation settings and
  the digital error flags, reached over the serial port.
  Assumes pins synchronous to clk and a synchronous active-high rst.
*/
`timescale 1ns/10ps
`include "gcr_regs.svh"
module gcr_bank #(
  parameter int CAL_CYCLES = `GCR_CAL_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic       mosi,
  output logic            miso,
  output logic            miso_oe,
  input  wire logic       alternate_scale_select,
  input  wire logic       external_selector_enable,
  input  wire logic [1:0] pin_output_dir,
  input  wire logic       clock_output_enable,
  input  wire logic       ext_clock_mode,
  input  wire logic       ext_clock,
  input  wire logic       spi_crc_fail,
  input  wire logic       register_map_check_fail,
  input  wire logic       rom_check_fail,
  output logic            general_pin_0,
  output logic            general_pin_0_oe,
  output logic            general_pin_1,
  output logic            general_pin_1_oe,
  output logic            general_pin_4,
  output logic            general_pin_4_oe,
  output logic [3:0]      input_gain_code,
  output gcr_pkg::gcr_scale_t output_scale,
  output logic            pump_clock,
  output logic            chop_clock,
  output logic            chop_tick,
  output logic            cal_busy
);
  logic       soft_rst;
  logic       bank_rst;
  logic       output_scale_select;
  logic [3:0] gain_code;
  logic [1:0] external_selector_code;
  logic       pump_clock_select;
  logic       clock_out_source;
  logic       sync_edge_polarity;
  logic [2:0] sync_div;
  logic [7:0] err_flags;
  logic [7:0] err_set;
  logic [7:0] err_clr;
  logic [7:0] rdata;
  logic       addr_strobe;
  logic       rd_frame;
  logic [6:0] addr;
  logic       wr_strobe;
  logic [7:0] wdata;
  logic       count_error;
  logic       mclk_level;
  logic       chop_level;
  logic       chop_tick_i;
  logic       pump_level;
  logic       wr_gain;
  logic       wr_sync;
  logic       wr_derr;
  logic       bad_addr;
  logic [15:0] cal_cnt;
  gcr_pkg::gcr_cal_state_t cal_state;

  function automatic logic addr_known(input logic [6:0] a);
    addr_known = (a == `GCR_ADDR_GAIN) || (a == `GCR_ADDR_SRST) ||
                 (a == `GCR_ADDR_SYNC) || (a == `GCR_ADDR_DERR);
  endfunction : addr_known

  gcr_spi u_spi (
    .clk         (clk),
    .rst         (rst),
    .cs_n        (cs_n),
    .sclk        (sclk),
    .mosi        (mosi),
    .rdata       (rdata),
    .miso        (miso),
    .miso_oe     (miso_oe),
    .addr_strobe (addr_strobe),
    .rd_frame    (rd_frame),
    .addr        (addr),
    .wr_strobe   (wr_strobe),
    .wdata       (wdata),
    .count_error (count_error)
  );

  // Clocks run on through a soft reset so the pump never glitches; pin 4 can, as its source resets to the master clock
  gcr_clkgen u_clk (
    .clk        (clk),
    .rst        (rst),
    .pump_slow  (pump_clock_select),
    .ext_mode   (ext_clock_mode),
    .ext_clk    (ext_clock),
    .ext_rising (sync_edge_polarity),
    .ext_div    (sync_div),
    .mclk_level (mclk_level),
    .chop_level (chop_level),
    .chop_tick  (chop_tick_i),
    .pump_level (pump_level)
  );

  assign bank_rst = rst | soft_rst;
  assign wr_gain  = wr_strobe && addr == `GCR_ADDR_GAIN;
  assign wr_sync  = wr_strobe && addr == `GCR_ADDR_SYNC;
  assign wr_derr  = wr_strobe && addr == `GCR_ADDR_DERR;
  assign bad_addr = (addr_strobe || wr_strobe) && !addr_known(addr);

  // Trigger is a one-cycle pulse, so the bit never reads back as 1
  always_ff @(posedge clk) begin
    if (rst) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_strobe && addr == `GCR_ADDR_SRST &&
                  wdata[`GCR_SRST_BIT];
    end
  end

  // Gain fields and selector code share one write
  always_ff @(posedge clk) begin
    if (bank_rst) begin
      output_scale_select    <= 1'b0;
      gain_code              <= `GCR_RST_GAIN_CODE;
      external_selector_code <= `GCR_RST_EXT_CODE;
    end else if (wr_gain) begin
      output_scale_select    <= wdata[`GCR_GAIN_SCALE_BIT];
      external_selector_code <= wdata[`GCR_GAIN_EXT_MSB:`GCR_GAIN_EXT_LSB];
      if (wdata[`GCR_GAIN_CODE_MSB:`GCR_GAIN_CODE_LSB] <=
          `GCR_GAIN_CODE_MAX) begin
        gain_code <= wdata[`GCR_GAIN_CODE_MSB:`GCR_GAIN_CODE_LSB];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (bank_rst) begin
      pump_clock_select  <= 1'b0;
      clock_out_source   <= 1'b0;
      sync_edge_polarity <= 1'b0;
      sync_div           <= `GCR_RST_SYNC_DIV;
    end else if (wr_sync) begin
      pump_clock_select  <= wdata[`GCR_SYNC_PUMP_BIT];
      clock_out_source   <= wdata[`GCR_SYNC_CLKOUT_BIT];
      sync_edge_polarity <= wdata[`GCR_SYNC_EDGE_POLARITY_BIT];
      if (wdata[`GCR_SYNC_DIV_MSB:`GCR_SYNC_DIV_LSB] <=
          `GCR_SYNC_DIV_MAX) begin
        sync_div <= wdata[`GCR_SYNC_DIV_MSB:`GCR_SYNC_DIV_LSB];
      end
    end
  end

  // Error flags: set beats a write-one clear in the same cycle
  always_comb begin
    err_set = 8'h00;
    err_set[`GCR_DERR_SPI_CRC]  = spi_crc_fail;
    err_set[`GCR_DERR_SPI_RW]   = bad_addr;
    err_set[`GCR_DERR_SCLK_CNT] = count_error;
    err_set[`GCR_DERR_MAP_CHK]  = register_map_check_fail;
    err_set[`GCR_DERR_ROM_CRC]  = rom_check_fail;
    err_clr = wr_derr ? (wdata & `GCR_DERR_FLAG_MASK) : 8'h00;
  end

  always_ff @(posedge clk) begin
    if (bank_rst) begin
      err_flags <= `GCR_RST_FLAGS;
    end else begin
      err_flags <= ((err_flags & ~err_clr) | err_set) &
                   `GCR_DERR_FLAG_MASK;
    end
  end

  // Start-up calibration after every reset; flag is never writable
  always_ff @(posedge clk) begin
    if (bank_rst) begin
      cal_state <= gcr_pkg::GCR_CAL_RUN;
      cal_cnt   <= 16'(CAL_CYCLES - 1);
      cal_busy  <= 1'b1;
    end else begin
      case (cal_state)
        gcr_pkg::GCR_CAL_RUN: begin
          if (cal_cnt == 16'h0000) begin
            cal_state <= gcr_pkg::GCR_CAL_IDLE;
            cal_busy  <= 1'b0;
          end else begin
            cal_cnt <= cal_cnt - 16'h0001;
          end
        end
        gcr_pkg::GCR_CAL_IDLE: begin
          cal_busy <= 1'b0;
        end
        default: begin
          cal_state <= gcr_pkg::GCR_CAL_IDLE;
        end
      endcase
    end
  end

  // Read mux; reserved bits read as zero
  always_comb begin
    rdata = 8'h00;
    case (addr)
      `GCR_ADDR_GAIN: begin
        rdata[`GCR_GAIN_SCALE_BIT] = output_scale_select;
        rdata[`GCR_GAIN_CODE_MSB:`GCR_GAIN_CODE_LSB] = gain_code;
        rdata[`GCR_GAIN_EXT_MSB:`GCR_GAIN_EXT_LSB] = external_selector_code;
      end
      `GCR_ADDR_SYNC: begin
        rdata[`GCR_SYNC_PUMP_BIT]   = pump_clock_select;
        rdata[`GCR_SYNC_CLKOUT_BIT] = clock_out_source;
        rdata[`GCR_SYNC_EDGE_POLARITY_BIT]    = sync_edge_polarity;
        rdata[`GCR_SYNC_DIV_MSB:`GCR_SYNC_DIV_LSB] = sync_div;
      end
      `GCR_ADDR_DERR: begin
        rdata = err_flags;
        rdata[`GCR_DERR_CAL_BIT] = cal_busy;
      end
      default: begin
        rdata = 8'h00;
      end
    endcase
  end

  // Analog settings presented as registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      input_gain_code <= `GCR_RST_GAIN_CODE;
      output_scale    <= gcr_pkg::GCR_SCALE_1;
    end else begin
      input_gain_code <= gain_code;
      if (output_scale_select) begin
        output_scale <= gcr_pkg::GCR_SCALE_1P375;
      end else if (alternate_scale_select) begin
        output_scale <= gcr_pkg::GCR_SCALE_1P25;
      end else begin
        output_scale <= gcr_pkg::GCR_SCALE_1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      general_pin_0    <= 1'b0;
      general_pin_0_oe <= 1'b0;
      general_pin_1    <= 1'b0;
      general_pin_1_oe <= 1'b0;
    end else begin
      general_pin_0    <= external_selector_code[0];
      general_pin_0_oe <= external_selector_enable & pin_output_dir[0];
      general_pin_1    <= external_selector_code[1];
      general_pin_1_oe <= external_selector_enable & pin_output_dir[1];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      general_pin_4    <= 1'b0;
      general_pin_4_oe <= 1'b0;
      pump_clock       <= 1'b0;
      chop_clock       <= 1'b0;
      chop_tick        <= 1'b0;
    end else begin
      general_pin_4    <= clock_out_source ? chop_level : mclk_level;
      general_pin_4_oe <= clock_output_enable;
      pump_clock       <= pump_level;
      chop_clock       <= chop_level;
      chop_tick        <= chop_tick_i;
    end
  end
endmodule : gcr_bank

// >>> tb/gcr_host.sv
/*
  Serial host model: mode 0 frames, MSB first, slow serial clock.
  Assumes the bank samples its serial pins on clk.
*/
`timescale 1ns/10ps
module gcr_host (
  input  wire logic clk,
  input  wire logic miso,
  output logic      cs_n,
  output logic      sclk,
  output logic      mosi
);
  initial {cs_n, sclk, mosi} = 3'b100;

  // Half period of 4 clk; fewer rises than 16 make a faulty frame
  task automatic xfer(input logic [15:0] frame, input int rises,
                      output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 0; i < rises; i++) begin
      mosi <= frame[15 - (i % 16)];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      if (i >= 8)
        rd = {rd[6:0], miso};
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    // Released line shows the inverse, never a stale bit
    mosi <= ~mosi;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask : xfer
endmodule : gcr_host

// >>> tb/gcr_bank_properties.sv
/*
  Concurrent checks on the ports of the configuration bank.
  Assumes a bind from the bench and one clock domain.
*/
`timescale 1ns/10ps
`include "gcr_regs.svh"
module gcr_bank_properties #(
  parameter int CAL_CYCLES = `GCR_CAL_CYCLES
) (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                cs_n,
  input wire logic                alternate_scale_select,
  input wire logic                external_selector_enable,
  input wire logic [1:0]          pin_output_dir,
  input wire logic                clock_output_enable,
  input wire logic                general_pin_0_oe,
  input wire logic                general_pin_4_oe,
  input wire logic [3:0]          input_gain_code,
  input wire gcr_pkg::gcr_scale_t output_scale,
  input wire logic                pump_clock,
  input wire logic                chop_tick,
  input wire logic                cal_busy
);
  int cal_len;

  always_ff @(posedge clk) begin
    if (rst || !cal_busy)
      cal_len <= 0;
    else
      cal_len <= cal_len + 1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_quiet; cs_n [*8]; endsequence
  sequence s_alt_hi; alternate_scale_select [*3]
    ##0 output_scale != gcr_pkg::GCR_SCALE_1P375; endsequence
  sequence s_alt_lo; !alternate_scale_select [*3]
    ##0 output_scale != gcr_pkg::GCR_SCALE_1P375; endsequence

  chk_scale_alt_hi: assert property (
    s_alt_hi |-> output_scale == gcr_pkg::GCR_SCALE_1P25)
    else $error("Scale ignores alternate select high");
  chk_scale_alt_lo: assert property (
    s_alt_lo |-> output_scale == gcr_pkg::GCR_SCALE_1)
    else $error("Scale ignores alternate select low");
  chk_scale_legal: assert property (output_scale != 2'b11)
    else $error("Illegal scale code");
  chk_gain_range: assert property (
    input_gain_code <= `GCR_GAIN_CODE_MAX)
    else $error("Reserved gain code reached the output");
  chk_gain_quiet: assert property (s_quiet |-> $stable(input_gain_code))
    else $error("Gain changed without a frame");
  chk_pin0_on: assert property (
    (external_selector_enable && pin_output_dir[0]) [*3] |-> general_pin_0_oe)
    else $error("Pin 0 not driven");
  chk_pin0_off: assert property (
    !(external_selector_enable && pin_output_dir[0]) [*3] |-> !general_pin_0_oe)
    else $error("Pin 0 driven while disabled");
  chk_pin4_off: assert property (
    !clock_output_enable [*3] |-> !general_pin_4_oe)
    else $error("Pin 4 driven while disabled");
  chk_cal_length: assert property (
    $fell(cal_busy) |-> cal_len >= CAL_CYCLES - 3 && cal_len <= CAL_CYCLES + 3)
    else $error("Calibration length wrong");
  chk_tick_single: assert property (chop_tick |=> !chop_tick [*8])
    else $error("Chop tick too close");
  chk_pump_spacing: assert property (
    $changed(pump_clock) |=> $stable(pump_clock) [*2])
    else $error("Pump clock too fast");
endmodule : gcr_bank_properties

// >>> tb/tb.sv
/*
  Self-checking bench of the gain and clock configuration bank.
  Assumes the host model and the checker are compiled first.
*/
`timescale 1ns/10ps
`include "gcr_regs.svh"
module tb;
  localparam int CAL = 400;
  logic clk = 1'b0, rst = 1'b1, ext_clock = 1'b0, ext_clock_mode = 1'b0;
  logic alternate_scale_select = 1'b0, external_selector_enable = 1'b0;
  logic [1:0] pin_output_dir = 2'b00;
  logic clock_output_enable = 1'b0, spi_crc_fail = 1'b0;
  logic register_map_check_fail = 1'b0, rom_check_fail = 1'b0;
  logic cs_n, sclk, mosi, miso, miso_oe, general_pin_0, general_pin_0_oe;
  logic general_pin_1, general_pin_1_oe, general_pin_4, general_pin_4_oe;
  logic pump_clock, chop_tick, cal_busy;
  logic [3:0] input_gain_code, g;
  gcr_pkg::gcr_scale_t output_scale;
  logic [2:0] dv;
  logic [7:0] r;
  int mismatches = 0, n_tests = 0, ext_cnt = 0, c;

  always #4 clk = ~clk;

  // About 2 MHz external clock, divider code 1 brings it to 1 MHz
  always @(posedge clk) begin
    ext_cnt <= (ext_cnt == 30) ? 0 : ext_cnt + 1;
    if (ext_cnt == 30)
      ext_clock <= ~ext_clock;
  end

  gcr_bank #(.CAL_CYCLES(CAL)) gcr_bank_inst (
    .clk, .rst, .cs_n, .sclk, .mosi, .miso, .miso_oe,
    .alternate_scale_select, .external_selector_enable, .pin_output_dir,
    .clock_output_enable, .ext_clock_mode, .ext_clock, .spi_crc_fail,
    .register_map_check_fail, .rom_check_fail, .general_pin_0,
    .general_pin_0_oe, .general_pin_1, .general_pin_1_oe, .general_pin_4,
    .general_pin_4_oe, .input_gain_code, .output_scale, .pump_clock,
    .chop_clock(), .chop_tick, .cal_busy);

  gcr_host gcr_host_inst (.clk, .miso, .cs_n, .sclk, .mosi);

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : check

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    gcr_host_inst.xfer({1'b0, a, d}, 16, x);
  endtask : wr

  task automatic rdc(input logic [6:0] a, input logic [7:0] want);
    logic [7:0] x;
    gcr_host_inst.xfer({1'b1, a, 8'h00}, 16, x);
    check(x, want);
  endtask : rdc

  // Rises of one output over n cycles: 0 pump, 1 chop tick, 2 pin 4
  task automatic rises(input int sel, input int n, input int want,
                       input int tol);
    logic p, v;
    int k;
    k = 0;
    p = 1'b1;
    repeat (n) begin
      @(posedge clk);
      v = (sel == 0) ? pump_clock : (sel == 1) ? chop_tick : general_pin_4;
      if (v === 1'b1 && p === 1'b0)
        k++;
      p = v;
    end
    check(8'(k >= want - tol && k <= want + tol), 8'h01);
  endtask : rises

  task automatic wait_cal();
    int k;
    for (k = 0; k < 2000 && cal_busy !== 1'b0; k++)
      @(posedge clk);
    if (k == 2000) begin
      mismatches++;
      conclude();
    end
  endtask : wait_cal

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({7'h0, cal_busy}, 8'h01);
    check({7'h0, miso_oe}, 8'h00);
    check({4'h0, input_gain_code}, 8'h00);
    check({6'h0, output_scale}, 8'h00);
    wait_cal();
    rdc(`GCR_ADDR_GAIN, 8'h00);
    rdc(`GCR_ADDR_SYNC, 8'h04);
    @(posedge clk);
    external_selector_enable <= 1'b1;
    pin_output_dir <= 2'b11;
    g = 4'h0;
    for (c = 0; c < 16; c++) begin
      @(posedge clk);
      alternate_scale_select <= c[2];
      wr(`GCR_ADDR_GAIN, {c[0], c[3:0], 1'b0, c[1:0]});
      if (c <= 11)
        g = c[3:0];
      check({4'h0, input_gain_code}, {4'h0, g});
      check({6'h0, output_scale}, c[0] ? 8'h02 : {7'h0, c[2]});
      check({6'h0, general_pin_1, general_pin_0}, {6'h0, c[1:0]});
      check({6'h0, general_pin_1_oe, general_pin_0_oe}, 8'h03);
    end
    rdc(`GCR_ADDR_GAIN, 8'hdb);
    @(posedge clk);
    pin_output_dir <= 2'b01;
    repeat (4) @(negedge clk);
    check({6'h0, general_pin_1_oe, general_pin_0_oe}, 8'h01);
    dv = 3'h4;
    for (c = 0; c < 8; c++) begin
      wr(`GCR_ADDR_SYNC, {5'h1a, c[2:0]});
      if (c <= 5)
        dv = c[2:0];
      rdc(`GCR_ADDR_SYNC, {5'h1a, dv});
    end
    rises(0, 1000, 64, 3);
    wr(`GCR_ADDR_SYNC, 8'h51);
    rises(0, 1000, 128, 3);
    @(posedge clk);
    clock_output_enable <= 1'b1;
    alternate_scale_select <= 1'b0;
    rises(2, 4000, 4, 1);
    rises(1, 4000, 4, 1);
    wr(`GCR_ADDR_SYNC, 8'h11);
    rises(2, 1000, 8, 1);
    @(posedge clk);
    ext_clock_mode <= 1'b1;
    rises(1, 4000, 4, 1);
    wr(`GCR_ADDR_SYNC, 8'h01);
    rises(1, 4000, 4, 1);
    wr(`GCR_ADDR_GAIN, 8'h5b);
    wr(`GCR_ADDR_SRST, 8'h01);
    check({4'h0, input_gain_code}, 8'h00);
    check({7'h0, cal_busy}, 8'h01);
    rdc(`GCR_ADDR_DERR, 8'h40);
    rdc(`GCR_ADDR_SRST, 8'h00);
    rdc(`GCR_ADDR_SYNC, 8'h04);
    wait_cal();
    gcr_host_inst.xfer({1'b0, `GCR_ADDR_GAIN, 8'h58}, 15, r);
    rdc(`GCR_ADDR_DERR, 8'h08);
    rdc(7'h10, 8'h00);
    @(posedge clk);
    {spi_crc_fail, register_map_check_fail, rom_check_fail} <= 3'b111;
    @(posedge clk);
    {spi_crc_fail, register_map_check_fail, rom_check_fail} <= 3'b000;
    rdc(`GCR_ADDR_DERR, 8'h3b);
    wr(`GCR_ADDR_DERR, 8'h48);
    rdc(`GCR_ADDR_DERR, 8'h33);
    wr(`GCR_ADDR_DERR, 8'h33);
    rdc(`GCR_ADDR_DERR, 8'h00);
    conclude();
  end
endmodule : tb

bind gcr_bank gcr_bank_properties #(.CAL_CYCLES(CAL_CYCLES))
  gcr_bank_properties_inst (.clk, .rst, .cs_n, .alternate_scale_select,
  .external_selector_enable, .pin_output_dir, .clock_output_enable,
  .general_pin_0_oe, .general_pin_4_oe, .input_gain_code, .output_scale,
  .pump_clock, .chop_tick, .cal_busy);
